/* core/spi_ctrl_defs.svh */
/*
  Constants for the serial port control and status block: register
  addresses, field positions, reset values and link timing counts.
  Assumes inclusion by bare name from the design.
*/
`ifndef SPI_CTRL_DEFS_SVH
`define SPI_CTRL_DEFS_SVH

// =====================================================================
// Register addresses
`define CTRL_ADDR       8'hF8
`define CFG_ADDR        8'hA1
`define DATA_ADDR       8'hA3
`define CTRL_BIT_BASE   8'hF8
`define CTRL_BIT_TOP    8'hFF

// =====================================================================
// Field positions and reset values
`define DONE_BIT        3'h7
`define WRITE_COLLISION_FLAG_BIT        3'h6
`define MODE_FAULT_FLAG_BIT        3'h5
`define RECEIVE_OVERRUN_FLAG_BIT      3'h4
`define MODE_HI_BIT     3'h3
`define MODE_LO_BIT     3'h2
`define TXE_BIT         3'h1
`define EN_BIT          3'h0
`define MASTER_ENABLE_BIT       3'h6
`define CTRL_RESET      8'h06
`define CFG_RESET       8'h00
`define MODE_THREE_WIRE 2'h0
`define MODE_MULTI      2'h1

// =====================================================================
// Timing
`define CLK_PERIOD_NS   5
`define SCK_PERIOD_NS   160
`define SCK_HALF_CYC    ((`SCK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define BYTE_LAST_BIT   3'h7

`endif

/* core/spi_ctrl_pkg.sv */
/*
  Types shared by the serial port control and status block.
  Assumes the constants header is on the include path.
*/
package spi_ctrl_pkg;

  // Control register layout, most significant field first
  typedef struct packed {
    logic       transfer_done_flag;
    logic       write_collision_flag;
    logic       mode_fault_flag;
    logic       receive_overrun_flag;
    logic [1:0] select_mode_field;
    logic       tx_buffer_empty;
    logic       port_enable;
  } ctrl_reg_type;

  // One processor access on the register port
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [7:0] bit_addr;
    logic       bit_val;
  } sfr_req_type;

  // Byte shifter states
  typedef enum logic [0:0] {
    XFER_IDLE  = 1'b0,
    XFER_SHIFT = 1'b1
  } xfer_state_type;

endpackage : spi_ctrl_pkg

/* core/spi_master_control_status.sv */
/*
  Serial port master with control/status register, mode fault,
  write collision and transmit-buffer-empty tracking.
  Assumes a processor register port on sys_clk and external pins
  that are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "spi_ctrl_defs.svh"

module spi_master_control_status
  import spi_ctrl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire sfr_req_type sfr_req,
  output logic [7:0]       sfr_rdata_q,
  output logic             port_irq_q,
  output logic             sck_q,
  output logic             mosi_q,
  input  wire logic        miso,
  input  wire logic        slave_select_line_in,
  output logic             slave_select_line_out_q,
  output logic             slave_select_line_oe_n_q
);

  // ===================================================================
  // Declarations
  ctrl_reg_type   ctrl_q;          // Control and status register
  logic           master_enable_q; // Master enable in config register
  logic [7:0]     txbuf_q;         // Transmit buffer
  logic           pend_q;          // Buffer holds a byte not yet moved
  logic [7:0]     rxbuf_q;         // Receive buffer
  logic [7:0]     shreg_q;         // Shift register
  logic [2:0]     bitn_q;          // Bit counter within byte
  logic [4:0]     div_q;           // Half-period divider
  xfer_state_type state_q;         // Shifter state
  logic [2:0]     sync_q [2];      // Pin synchronisers
  logic [1:0]     lvl_q;           // Filtered pin levels
  logic [7:0]     wmask;           // Bits touched by this write
  logic [7:0]     wval;            // Values written
  logic           data_wr;         // Data register write
  logic           tick;            // Half period elapsed
  logic           load;            // Buffer moves to shifter
  logic           byte_end;        // Last falling clock edge
  logic           fault;           // Mode fault condition
  logic           active;          // Port enabled as master

  // ===================================================================
  // Pin synchronisers: three stages, level taken when 2nd and 3rd agree
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync_q[i] <= 3'h7;
          lvl_q[i]  <= 1'b1;
        end
        else
        begin
          sync_q[i] <= {sync_q[i][1:0],
                        (i == 0) ? miso : slave_select_line_in};
          if (sync_q[i][1] == sync_q[i][2])
          begin
            lvl_q[i] <= sync_q[i][2];
          end
        end
      end
    end
  endgenerate

  // ===================================================================
  // Write decode
  always_comb
  begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (sfr_req.wr && sfr_req.addr == `CTRL_ADDR)
    begin
      wmask = 8'hFF; // Whole-byte write
      wval  = sfr_req.wdata;
    end
    else if (sfr_req.bit_wr && sfr_req.bit_addr >= `CTRL_BIT_BASE
             && sfr_req.bit_addr <= `CTRL_BIT_TOP)
    begin
      wmask = 8'h01 << sfr_req.bit_addr[2:0]; // Single bit only
      wval  = {8{sfr_req.bit_val}};
    end
  end

  // Events of the current cycle
  assign data_wr  = sfr_req.wr && (sfr_req.addr == `DATA_ADDR);
  assign active   = ctrl_q.port_enable && master_enable_q;
  assign tick     = (div_q == 5'(`SCK_HALF_CYC - 1));
  assign load     = active && pend_q && (state_q == XFER_IDLE);
  assign byte_end = (state_q == XFER_SHIFT) && tick && sck_q
                    && (bitn_q == `BYTE_LAST_BIT);
  // Select low while master in multi-master mode
  assign fault    = !lvl_q[1] && master_enable_q
                    && (ctrl_q.select_mode_field == `MODE_MULTI);

  // ===================================================================
  // Control register: hardware set wins over software clear
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= ctrl_reg_type'(`CTRL_RESET); // Mode 01 default
    end
    else
    begin
      // Done flag set at byte end, else software writes it
      if (byte_end)
        ctrl_q.transfer_done_flag <= 1'b1;
      else if (wmask[`DONE_BIT])
        ctrl_q.transfer_done_flag <= wval[`DONE_BIT];
      // Collision on data write during a transfer
      if (data_wr && state_q == XFER_SHIFT)
        ctrl_q.write_collision_flag <= 1'b1;
      else if (wmask[`WRITE_COLLISION_FLAG_BIT])
        ctrl_q.write_collision_flag <= wval[`WRITE_COLLISION_FLAG_BIT];
      // Mode fault flag
      if (fault)
        ctrl_q.mode_fault_flag <= 1'b1;
      else if (wmask[`MODE_FAULT_FLAG_BIT])
        ctrl_q.mode_fault_flag <= wval[`MODE_FAULT_FLAG_BIT];
      // Overrun is slave-only; software may still write it
      if (wmask[`RECEIVE_OVERRUN_FLAG_BIT])
        ctrl_q.receive_overrun_flag <= wval[`RECEIVE_OVERRUN_FLAG_BIT];
      // Select mode field
      if (wmask[`MODE_HI_BIT])
        ctrl_q.select_mode_field[1] <= wval[`MODE_HI_BIT];
      if (wmask[`MODE_LO_BIT])
        ctrl_q.select_mode_field[0] <= wval[`MODE_LO_BIT];
      // Empty set on move to shifter, cleared on data write while idle
      if (load)
        ctrl_q.tx_buffer_empty <= 1'b1;
      else if (data_wr && state_q == XFER_IDLE)
        ctrl_q.tx_buffer_empty <= 1'b0;
      // Port enable, dropped by a mode fault
      if (fault)
        ctrl_q.port_enable <= 1'b0;
      else if (wmask[`EN_BIT])
        ctrl_q.port_enable <= wval[`EN_BIT];
    end
  end

  // ===================================================================
  // Config register: master enable, dropped by a mode fault
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      master_enable_q <= 1'(`CFG_RESET >> `MASTER_ENABLE_BIT);
    end
    else if (fault)
    begin
      master_enable_q <= 1'b0;
    end
    else if (sfr_req.wr && sfr_req.addr == `CFG_ADDR)
    begin
      master_enable_q <= sfr_req.wdata[`MASTER_ENABLE_BIT];
    end
  end

  // ===================================================================
  // Transmit buffer; writes during a transfer are dropped
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      txbuf_q <= 8'h00;
      pend_q  <= 1'b0;
    end
    else if (data_wr && state_q == XFER_IDLE)
    begin
      txbuf_q <= sfr_req.wdata; // Fill buffer
      pend_q  <= 1'b1;
    end
    else if (load)
    begin
      pend_q <= 1'b0;
    end
  end

  // ===================================================================
  // Byte shifter: clock low idle, sample on rise, shift on fall
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= XFER_IDLE;
      shreg_q <= 8'h00;
      bitn_q  <= 3'h0;
      div_q   <= 5'h00;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
      rxbuf_q <= 8'h00;
    end
    else if (!active)
    begin
      // Disabled: abort and hold lines idle
      state_q <= XFER_IDLE;
      div_q   <= 5'h00;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        XFER_IDLE:
        begin
          if (load)
          begin
            // Start at once, first bit on data line
            shreg_q <= txbuf_q;
            mosi_q  <= txbuf_q[7];
            bitn_q  <= 3'h0;
            div_q   <= 5'h00;
            state_q <= XFER_SHIFT;
          end
        end
        XFER_SHIFT:
        begin
          div_q <= tick ? 5'h00 : div_q + 5'h01;
          if (tick && !sck_q)
          begin
            // Rising edge: take input bit
            sck_q   <= 1'b1;
            shreg_q <= {shreg_q[6:0], lvl_q[0]};
          end
          else if (tick)
          begin
            // Falling edge: next bit or finish
            sck_q <= 1'b0;
            if (byte_end)
            begin
              rxbuf_q <= shreg_q;
              mosi_q  <= 1'b0;
              state_q <= XFER_IDLE;
            end
            else
            begin
              mosi_q <= shreg_q[7];
              bitn_q <= bitn_q + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // ===================================================================
  // Slave select pin by mode
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slave_select_line_out_q  <= 1'b1;
      slave_select_line_oe_n_q <= 1'b1;
    end
    else if (ctrl_q.select_mode_field[1])
    begin
      // Single-master: drive low bit out
      slave_select_line_out_q  <= ctrl_q.select_mode_field[0];
      slave_select_line_oe_n_q <= 1'b0;
    end
    else
    begin
      // Modes 00 and 01: released; 00 ignores it
      slave_select_line_out_q  <= 1'b1;
      slave_select_line_oe_n_q <= 1'b1;
    end
  end

  // ===================================================================
  // Read data and interrupt request
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sfr_rdata_q <= 8'h00;
      port_irq_q  <= 1'b0;
    end
    else
    begin
      unique case (sfr_req.addr)
        `CTRL_ADDR: sfr_rdata_q <= ctrl_q;
        `CFG_ADDR:  sfr_rdata_q <= {1'b0, master_enable_q, 6'h00};
        `DATA_ADDR: sfr_rdata_q <= rxbuf_q;
        default:    sfr_rdata_q <= 8'h00; // Unmapped reads zero
      endcase
      // Held while any flag stands
      port_irq_q <= ctrl_q.transfer_done_flag
                    | ctrl_q.write_collision_flag
                    | ctrl_q.mode_fault_flag
                    | ctrl_q.receive_overrun_flag;
    end
  end

endmodule : spi_master_control_status

/* dv/spi_ctrl_asserts.sv */
/* Port checks for the serial port control block.
   Assumes a bind to the top module and a single clock domain. */
`timescale 1ns/1ps
module spi_ctrl_asserts
  import spi_ctrl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire sfr_req_type sfr_req,
  input wire logic        port_irq_q,
  input wire logic        sck_q,
  input wire logic        mosi_q,
  input wire logic        slave_select_line_out_q,
  input wire logic        slave_select_line_oe_n_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // =====================================================
  // Helpers
  logic [4:0] hi_q;    // Cycles sck seen high
  logic [2:0] fall_q;  // Falls of sck, modulo a byte
  logic       sck_p_q; // Sck one cycle ago
  logic       w_ctl;   // Byte write to control
  logic       w_dat;   // Byte write to data
  assign w_ctl = sfr_req.wr && sfr_req.addr == 8'hF8;
  assign w_dat = sfr_req.wr && sfr_req.addr == 8'hA3;
  // Count sck high time and falling edges
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      hi_q    <= 5'h00;
      fall_q  <= 3'h0;
      sck_p_q <= 1'b0;
    end
    else
    begin
      hi_q    <= sck_q ? hi_q + 5'h01 : 5'h00;
      fall_q  <= fall_q + 3'(sck_p_q && !sck_q);
      sck_p_q <= sck_q;
    end
  // =====================================================
  // Assertions
  chk_sel_drive:
    assert property (w_ctl && sfr_req.wdata[3] |-> ##2
      (!slave_select_line_oe_n_q && slave_select_line_out_q ==
       $past(sfr_req.wdata[2], 2)))
    else $error("select not driven from mode bit");
  chk_sel_input:
    assert property (w_ctl && !sfr_req.wdata[3] |-> ##2
      slave_select_line_oe_n_q)
    else $error("select driven outside mode 1x");
  chk_irq_hold:
    assert property (port_irq_q && !(sfr_req.wr || sfr_req.bit_wr)
      && !$past(sfr_req.wr || sfr_req.bit_wr) |=> port_irq_q)
    else $error("interrupt dropped without software");
  chk_idle_off:
    assert property (w_ctl && !sfr_req.wdata[0] |-> ##3
      (!sck_q && !mosi_q) [*4])
    else $error("link active while disabled");
  chk_sck_half:
    assert property ($fell(sck_q) |-> hi_q == 5'h10)
    else $error("sck high time wrong");
  chk_byte_irq:
    assert property ($fell(sck_q) && fall_q == 3'h7 |-> ##[1:3]
      port_irq_q)
    else $error("no interrupt after byte");
  chk_mosi_low:
    assert property ($changed(mosi_q) |-> !sck_q)
    else $error("mosi moved while sck high");
  chk_write_collision_flag_irq:
    assert property (w_dat && sck_q |-> ##[1:3] port_irq_q)
    else $error("no interrupt on collision");
endmodule : spi_ctrl_asserts

bind spi_master_control_status spi_ctrl_asserts chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req),
  .port_irq_q(port_irq_q), .sck_q(sck_q), .mosi_q(mosi_q),
  .slave_select_line_out_q(slave_select_line_out_q),
  .slave_select_line_oe_n_q(slave_select_line_oe_n_q));

/* dv/spi_slave_model.sv */
/* Behavioural serial slave: returns one byte, captures one byte.
   Assumes a reload strobe from the bench while sck is idle and a
   select line that is pulled high when nobody drives it. */
`timescale 1ns/1ps
module spi_slave_model
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       select_n,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] tx_sh; // Outgoing bits, MSB first
  // Deselected: output let go, seen as the inverse bit
  assign miso = select_n ? ~tx_sh[7] : tx_sh[7];
  // Capture on rising sck, MSB first, only while selected
  always @(posedge sck)
    if (!select_n)
      rx_byte <= {rx_byte[6:0], mosi};
  // Next bit on falling sck; refill with the inverse of bit 0
  always @(negedge sck or posedge load)
    if (load)
      tx_sh <= tx_byte;
    else
      tx_sh <= {tx_sh[6:0], ~tx_sh[0]};
endmodule : spi_slave_model

/* dv/tb_spi_master_control_status.sv */
/* Self-checking bench for the serial port control block.
   Assumes core files, checker and slave model compiled first. */
`timescale 1ns/1ps
module tb_spi_master_control_status
  import spi_ctrl_pkg::*;
;
  sfr_req_type sfr_req;     // Register port request
  logic        sys_clk;     // 200 MHz clock
  logic        rstn;        // Reset, active low
  logic        miso;        // Slave data out
  logic        ss_in;       // Select pin level
  logic        load;        // Slave reload strobe
  logic        irq;         // Interrupt request
  logic        sck;         // Serial clock
  logic        mosi;        // Master data out
  logic        ss_out;      // Select drive value
  logic        ss_oe_n;     // Select drive enable
  logic [7:0]  rdata;       // Read data
  logic [7:0]  tx_b;        // Byte the slave returns
  logic [7:0]  rx_b;        // Byte the slave took
  int          n_fail;      // Mismatches
  int          checks_done; // Comparisons
  int          m;           // Loop index
  int          n;           // Cycle count

  spi_master_control_status dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req),
    .sfr_rdata_q(rdata), .port_irq_q(irq), .sck_q(sck),
    .mosi_q(mosi), .miso(miso), .slave_select_line_in(ss_in),
    .slave_select_line_out_q(ss_out),
    .slave_select_line_oe_n_q(ss_oe_n));
  // Released select line is pulled high at the slave
  spi_slave_model slave_u (
    .sck(sck), .mosi(mosi), .select_n(ss_oe_n | ss_out),
    .load(load), .tx_byte(tx_b),
    .miso(miso), .rx_byte(rx_b));

  // =====================================================
  // Expectations
  function automatic logic [7:0] ctl(input logic [2:0] f,
    input logic [1:0] md, input logic e);
    return {f, 1'b0, md, 1'b1, e};
  endfunction : ctl
  function automatic logic [7:0] sel(input logic [1:0] md);
    return md[1] ? {7'h00, md[0]} : 8'h03;
  endfunction : sel
  // =====================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_req <= {1'b1, a, d, 1'b0, 8'h00, 1'b0};
    @(posedge sys_clk);
    sfr_req <= {1'b0, 8'hF8, d, 1'b0, 8'h00, 1'b0};
  endtask : wr
  task automatic bw(input logic [2:0] b, input logic v);
    @(posedge sys_clk);
    sfr_req <= {1'b0, 8'hF8, 8'h00, 1'b1, 8'hF8 + 8'(b), v};
    @(posedge sys_clk);
    sfr_req.bit_wr <= 1'b0;
  endtask : bw
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_req.addr <= a;
    @(posedge sys_clk);
    #1 chk(rdata, exp);
  endtask : rd
  task automatic prep(input logic [7:0] s);
    @(posedge sys_clk);
    tx_b <= s;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
  endtask : prep
  // Wait for the byte, check both directions, clear flags
  task automatic fin(input logic [7:0] b, s, c);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(8'(n < 400), 8'h01);
    chk(rx_b, b);
    rd(8'hA3, s);
    rd(8'hF8, c);
    wr(8'hF8, c & 8'h1F);
    repeat (3) @(posedge sys_clk);
    #1 chk(8'(irq), 8'h00);
  endtask : fin
  task automatic xfer(input logic [7:0] b, s, input logic coll);
    prep(s);
    wr(8'hA3, b);
    @(posedge sys_clk);
    #1 chk(8'(rdata[1]), 8'h00);
    @(posedge sys_clk);
    #1 chk(8'(rdata[1]), 8'h01);
    if (coll)
    begin
      repeat (60) @(posedge sys_clk);
      wr(8'hA3, ~b);
      repeat (220) @(posedge sys_clk);
    end
    fin(b, s, ctl({1'b1, coll, 1'b0}, 2'h2, 1'b1));
    // 16 halves of 16 cycles after the load, irq one cycle later
    if (!coll)
      chk(8'(n == 256), 8'h01);
  endtask : xfer
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // =====================================================
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    give_verdict();
  end
  // =====================================================
  // Tests
  initial
  begin
    sfr_req = '0;
    rstn = 1'b0;
    ss_in = 1'b1;
    load = 1'b1;
    tx_b = 8'h00;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'h7C3BA0B3));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    load <= 1'b0;
    rd(8'hF8, ctl(3'h0, 2'h1, 1'b0));
    rd(8'h55, 8'h00);
    bw(3'h0, 1'b1);
    rd(8'hF8, ctl(3'h0, 2'h1, 1'b1));
    bw(3'h3, 1'b1);
    rd(8'hF8, ctl(3'h0, 2'h3, 1'b1));
    wr(8'hF8, 8'h00);
    rd(8'hF8, ctl(3'h0, 2'h0, 1'b0));
    for (m = 0; m < 4; m++)
    begin
      wr(8'hF8, 8'(m << 2));
      repeat (3) @(posedge sys_clk);
      #1 chk({6'h00, ss_oe_n, ss_out}, sel(2'(m)));
    end
    $display("test registers and select done");
    wr(8'hA1, 8'h40);
    // Mode 10: select driven low, slave selected
    wr(8'hF8, 8'h09);
    xfer(8'hFF, 8'h00, 1'b0);
    repeat (3) xfer(8'($urandom), 8'($urandom), 1'b0);
    xfer(8'hA5, 8'h3C, 1'b1);
    $display("test transfers done");
    wr(8'hF8, 8'h08);
    prep(8'h5A);
    wr(8'hA3, 8'hC3);
    n = 0;
    repeat (300)
    begin
      @(posedge sys_clk);
      n += 32'(sck);
    end
    chk(8'(n), 8'h00);
    wr(8'hF8, 8'h09);
    fin(8'hC3, 8'h5A, ctl(3'h4, 2'h2, 1'b1));
    $display("test disable done");
    wr(8'hF8, 8'h05);
    ss_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(8'hF8, ctl(3'h1, 2'h1, 1'b0));
    rd(8'hA1, 8'h00);
    chk(8'(irq), 8'h01);
    ss_in <= 1'b1;
    $display("test mode fault done");
    give_verdict();
  end
endmodule : tb_spi_master_control_status
